/* hw/dcbs_pkg.sv */
package dcbs_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_HZ = 25000000;
   localparam int TICK_NS = 40;
   localparam int BUF_RATE_HZ = 16000;
   // Drive cycle length in clocks, rounded down
   localparam int DRIVE_CYC_CLKS = CLK_HZ / BUF_RATE_HZ;
   localparam int CYC_W = 11;
   localparam logic [CYC_W-1:0] DRIVE_CYC_LAST = CYC_W'(DRIVE_CYC_CLKS - 1);
   // Drive cycles per controller cycle
   localparam int DCYC_PER_CCYC = 4;
   localparam int DC_W = 2;
   localparam logic [DC_W-1:0] DC_LAST = DC_W'(DCYC_PER_CCYC - 1);
   // ****************************************
   // Network sizes
   // ****************************************
   localparam int MAX_AXES = 32;
   localparam int AXIS_W = 5;
   localparam int NODE_AXES = 4;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // ****************************************
   // Frame kinds
   // ****************************************
   localparam logic [1:0] KIND_CYC = 2'h0;
   localparam logic [1:0] KIND_SVC = 2'h1;
   localparam logic [1:0] KIND_ADDR = 2'h2;
   localparam logic [1:0] KIND_STRB = 2'h3;
   typedef enum logic [1:0] {DCBS_IDLE, DCBS_SEND} dcbs_tx_type;
endpackage

/* hw/dcbs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dcbs_link_if;
   import dcbs_pkg::*;
   // Controller to node pair
   logic dn_valid;
   logic [1:0] dn_kind;
   logic [ADDR_W-1:0] dn_node;
   logic [AXIS_W-1:0] dn_axis;
   logic [DATA_W-1:0] dn_data;
   // Node to controller pair
   logic up_valid;
   logic [1:0] up_kind;
   logic [ADDR_W-1:0] up_node;
   logic [AXIS_W-1:0] up_axis;
   logic [DATA_W-1:0] up_data;
   modport ctrl (output dn_valid, dn_kind, dn_node, dn_axis, dn_data,
      input up_valid, up_kind, up_node, up_axis, up_data);
   modport node (input dn_valid, dn_kind, dn_node, dn_axis, dn_data,
      output up_valid, up_kind, up_node, up_axis, up_data);
endinterface
`default_nettype wire

/* hw/dcbs_node.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Node checks buffers every drive cycle
// - Controller cycle is whole drive cycles
// - Cyclic and service use separate buffers
// - Controller places slots at 40 ns
// - Packet size follows node axis count
// - Fresh cyclic demand each controller cycle
// - Drives adopt cyclic data on strobe
// - One service request per node cycle
// - Service not in cyclic drive cycle
// - Buffers updated at 16 kHz
// - Up to 32 axes networked
// - Separate receive and transmit pairs
// - Service channel queries axis parameters
// - Timing on 25 MHz clock tick
// - Controller assigns node addresses
module dcbs_node
   import dcbs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Link
   dcbs_link_if.node link,
   // Drive side
   output logic [NODE_AXES*DATA_W-1:0] drive_demand_o,
   output logic drive_update_o,
   output logic drive_cycle_o,
   output logic [ADDR_W-1:0] node_addr_o,
   output logic addr_valid_o,
   output logic svc_seen_o,
   input wire logic [NODE_AXES*DATA_W-1:0] drive_resp_i,
   input wire logic [NODE_AXES*DATA_W-1:0] param_i
);
   // ****************************************
   // Registers
   // ****************************************
   logic [CYC_W-1:0] cyc_reg, cyc_next;
   logic [DATA_W-1:0] cbuf_reg [NODE_AXES];
   logic [DATA_W-1:0] cbuf_next [NODE_AXES];
   logic [NODE_AXES*DATA_W-1:0] dem_reg, dem_next;
   logic upd_reg, upd_next, tick_reg, tick_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic aval_reg, aval_next;
   logic svc_pend_reg, svc_pend_next, svc_seen_reg, svc_seen_next;
   logic [AXIS_W-1:0] svc_axis_reg, svc_axis_next;
   logic uv_reg, uv_next;
   logic [1:0] uk_reg, uk_next;
   logic [AXIS_W-1:0] ua_reg, ua_next;
   logic [DATA_W-1:0] ud_reg, ud_next;
   logic [1:0] ax_cnt_reg, ax_cnt_next;
   logic resp_pend_reg, resp_pend_next;
   logic mine;

   function automatic logic [1:0] local_axis(input logic [AXIS_W-1:0] a);
      return a[1:0];
   endfunction

   assign mine = aval_reg && link.dn_node == addr_reg;

   always_comb begin
      cyc_next = cyc_reg;
      tick_next = 1'b0;
      cbuf_next = cbuf_reg;
      dem_next = dem_reg;
      upd_next = 1'b0;
      addr_next = addr_reg;
      aval_next = aval_reg;
      svc_pend_next = svc_pend_reg;
      svc_axis_next = svc_axis_reg;
      svc_seen_next = 1'b0;
      uv_next = 1'b0;
      uk_next = uk_reg;
      ua_next = ua_reg;
      ud_next = ud_reg;
      ax_cnt_next = ax_cnt_reg;
      resp_pend_next = resp_pend_reg;
      if (cyc_reg == DRIVE_CYC_LAST) begin
         cyc_next = '0;
         tick_next = 1'b1;
      end else begin
         cyc_next = cyc_reg + CYC_W'(1);
      end
      if (link.dn_valid) begin
         case (link.dn_kind)
            KIND_ADDR: begin
               addr_next = link.dn_node;
               aval_next = 1'b1;
            end
            KIND_CYC: begin
               if (mine) begin
                  cbuf_next[local_axis(link.dn_axis)] = link.dn_data;
               end
            end
            KIND_SVC: begin
               if (mine) begin
                  svc_pend_next = 1'b1;
                  svc_axis_next = link.dn_axis;
               end
            end
            KIND_STRB: begin
               for (int i = 0; i < NODE_AXES; i++) begin
                  dem_next[i*DATA_W +: DATA_W] = cbuf_reg[i];
               end
               upd_next = 1'b1;
               resp_pend_next = aval_reg;
               ax_cnt_next = '0;
            end
            default: begin
            end
         endcase
      end
      // Buffer check once per drive cycle
      if (tick_reg) begin
         if (svc_pend_reg) begin
            svc_pend_next = 1'b0;
            svc_seen_next = 1'b1;
            uv_next = 1'b1;
            uk_next = KIND_SVC;
            ua_next = svc_axis_reg;
            ud_next = param_i[local_axis(svc_axis_reg)*DATA_W +: DATA_W];
         end
      end else if (resp_pend_reg) begin
         uv_next = 1'b1;
         uk_next = KIND_CYC;
         ua_next = AXIS_W'(ax_cnt_reg);
         ud_next = drive_resp_i[ax_cnt_reg*DATA_W +: DATA_W];
         ax_cnt_next = ax_cnt_reg + 2'h1;
         if (ax_cnt_reg == 2'(NODE_AXES - 1)) begin
            resp_pend_next = 1'b0;
         end
      end
      // Service arriving while consumed is kept
      if (link.dn_valid && link.dn_kind == KIND_SVC && mine) begin
         svc_pend_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cyc_reg <= '0;
         tick_reg <= 1'b0;
         for (int i = 0; i < NODE_AXES; i++) begin
            cbuf_reg[i] <= '0;
         end
         dem_reg <= '0;
         upd_reg <= 1'b0;
         addr_reg <= '0;
         aval_reg <= 1'b0;
         svc_pend_reg <= 1'b0;
         svc_axis_reg <= '0;
         svc_seen_reg <= 1'b0;
         uv_reg <= 1'b0;
         uk_reg <= '0;
         ua_reg <= '0;
         ud_reg <= '0;
         ax_cnt_reg <= '0;
         resp_pend_reg <= 1'b0;
      end else begin
         cyc_reg <= cyc_next;
         tick_reg <= tick_next;
         cbuf_reg <= cbuf_next;
         dem_reg <= dem_next;
         upd_reg <= upd_next;
         addr_reg <= addr_next;
         aval_reg <= aval_next;
         svc_pend_reg <= svc_pend_next;
         svc_axis_reg <= svc_axis_next;
         svc_seen_reg <= svc_seen_next;
         uv_reg <= uv_next;
         uk_reg <= uk_next;
         ua_reg <= ua_next;
         ud_reg <= ud_next;
         ax_cnt_reg <= ax_cnt_next;
         resp_pend_reg <= resp_pend_next;
      end
   end

   assign drive_demand_o = dem_reg;
   assign drive_update_o = upd_reg;
   assign drive_cycle_o = tick_reg;
   assign node_addr_o = addr_reg;
   assign addr_valid_o = aval_reg;
   assign svc_seen_o = svc_seen_reg;
   assign link.up_valid = uv_reg;
   assign link.up_kind = uk_reg;
   assign link.up_node = addr_reg;
   assign link.up_axis = ua_reg;
   assign link.up_data = ud_reg;
endmodule
`default_nettype wire

/* hw/dcbs_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module dcbs_ctrl
   import dcbs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Link
   dcbs_link_if.ctrl link,
   // User side
   input wire logic [ADDR_W-1:0] node_addr_i,
   input wire logic [NODE_AXES*DATA_W-1:0] demand_i,
   input wire logic svc_req_i,
   input wire logic [AXIS_W-1:0] svc_axis_i,
   output logic svc_busy_o,
   output logic ccyc_start_o,
   output logic resp_valid_o,
   output logic [1:0] resp_kind_o,
   output logic [AXIS_W-1:0] resp_axis_o,
   output logic [DATA_W-1:0] resp_data_o
);
   // ****************************************
   // Schedule state
   // ****************************************
   dcbs_tx_type st_reg, st_next;
   logic [CYC_W-1:0] cyc_reg, cyc_next;
   logic [DC_W-1:0] dc_reg, dc_next;
   logic [2:0] slot_reg, slot_next;
   logic init_reg, init_next;
   logic svc_pend_reg, svc_pend_next;
   logic [AXIS_W-1:0] svc_axis_reg, svc_axis_next;
   logic ccs_reg, ccs_next;
   logic dv_reg, dv_next;
   logic [1:0] dk_reg, dk_next;
   logic [AXIS_W-1:0] da_reg, da_next;
   logic [DATA_W-1:0] dd_reg, dd_next;
   logic rv_reg;
   logic [1:0] rk_reg;
   logic [AXIS_W-1:0] ra_reg;
   logic [DATA_W-1:0] rd_reg;
   logic [ADDR_W-1:0] dn_node_reg;

   always_comb begin
      st_next = st_reg;
      cyc_next = cyc_reg;
      dc_next = dc_reg;
      slot_next = slot_reg;
      init_next = init_reg;
      svc_pend_next = svc_pend_reg;
      svc_axis_next = svc_axis_reg;
      ccs_next = 1'b0;
      dv_next = 1'b0;
      dk_next = dk_reg;
      da_next = da_reg;
      dd_next = dd_reg;
      if (svc_req_i && !svc_pend_reg) begin
         svc_pend_next = 1'b1;
         svc_axis_next = svc_axis_i;
      end
      if (cyc_reg == DRIVE_CYC_LAST) begin
         cyc_next = '0;
         dc_next = dc_reg + DC_W'(1);
         if (dc_reg == DC_LAST) begin
            ccs_next = 1'b1;
         end
      end else begin
         cyc_next = cyc_reg + CYC_W'(1);
      end
      case (st_reg)
         DCBS_IDLE: begin
            if (!init_reg) begin
               dv_next = 1'b1;
               dk_next = KIND_ADDR;
               init_next = 1'b1;
            end else if (cyc_reg == '0 && dc_reg == '0) begin
               st_next = DCBS_SEND;
               slot_next = '0;
            end else if (cyc_reg == '0 && dc_reg == DC_W'(1) && svc_pend_reg) begin
               // Service in a later drive cycle
               dv_next = 1'b1;
               dk_next = KIND_SVC;
               da_next = svc_axis_reg;
               svc_pend_next = 1'b0;
            end
         end
         DCBS_SEND: begin
            dv_next = 1'b1;
            // Demand to every axis, then strobe
            if (slot_reg == 3'(NODE_AXES)) begin
               dk_next = KIND_STRB;
               st_next = DCBS_IDLE;
            end else begin
               dk_next = KIND_CYC;
               da_next = AXIS_W'(slot_reg);
               dd_next = demand_i[slot_reg[1:0]*DATA_W +: DATA_W];
               slot_next = slot_reg + 3'h1;
            end
         end
         default: st_next = DCBS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_reg <= DCBS_IDLE;
         cyc_reg <= '0;
         dc_reg <= '0;
         slot_reg <= '0;
         init_reg <= 1'b0;
         svc_pend_reg <= 1'b0;
         svc_axis_reg <= '0;
         ccs_reg <= 1'b0;
         dv_reg <= 1'b0;
         dk_reg <= '0;
         da_reg <= '0;
         dd_reg <= '0;
         rv_reg <= 1'b0;
         rk_reg <= '0;
         ra_reg <= '0;
         rd_reg <= '0;
         dn_node_reg <= '0;
      end else begin
         st_reg <= st_next;
         cyc_reg <= cyc_next;
         dc_reg <= dc_next;
         slot_reg <= slot_next;
         init_reg <= init_next;
         svc_pend_reg <= svc_pend_next;
         svc_axis_reg <= svc_axis_next;
         ccs_reg <= ccs_next;
         dv_reg <= dv_next;
         dk_reg <= dk_next;
         da_reg <= da_next;
         dd_reg <= dd_next;
         rv_reg <= link.up_valid;
         rk_reg <= link.up_kind;
         ra_reg <= link.up_axis;
         rd_reg <= link.up_data;
         // Target node registered with its frame
         dn_node_reg <= node_addr_i;
      end
   end

   assign link.dn_valid = dv_reg;
   assign link.dn_kind = dk_reg;
   assign link.dn_node = dn_node_reg;
   assign link.dn_axis = da_reg;
   assign link.dn_data = dd_reg;
   assign svc_busy_o = svc_pend_reg;
   assign ccyc_start_o = ccs_reg;
   assign resp_valid_o = rv_reg;
   assign resp_kind_o = rk_reg;
   assign resp_axis_o = ra_reg;
   assign resp_data_o = rd_reg;
endmodule
`default_nettype wire

/* sim/dcbs_link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dcbs_link_sva
   import dcbs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Controller to node
   input wire logic dn_valid,
   input wire logic [1:0] dn_kind,
   input wire logic [ADDR_W-1:0] dn_node,
   input wire logic [AXIS_W-1:0] dn_axis,
   input wire logic [DATA_W-1:0] dn_data,
   // Node to controller
   input wire logic up_valid,
   input wire logic [1:0] up_kind,
   input wire logic [ADDR_W-1:0] up_node,
   input wire logic [AXIS_W-1:0] up_axis,
   input wire logic [DATA_W-1:0] up_data
);
   // ****************************************
   // Link frame checks
   // ****************************************
   localparam int CC = DCYC_PER_CCYC * DRIVE_CYC_CLKS;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   wire strb = dn_valid && dn_kind == KIND_STRB;
   wire svc = dn_valid && dn_kind == KIND_SVC;
   wire adr = dn_valid && dn_kind == KIND_ADDR;
   logic [15:0] cnt_reg;
   logic seen_reg;
   logic adrn_reg;
   logic [1:0] svcn_reg;
   // Clocks since strobe, frames per cycle
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_reg <= 16'h0;
         seen_reg <= 1'b0;
         adrn_reg <= 1'b0;
         svcn_reg <= 2'h0;
      end else begin
         cnt_reg <= strb ? 16'h0 : cnt_reg + 16'h1;
         seen_reg <= seen_reg | strb;
         adrn_reg <= adrn_reg | adr;
         svcn_reg <= strb ? 2'h0 : svcn_reg + {1'b0, svc};
      end
   end
   property p_strb_order;
      strb |-> $past(dn_valid) && $past(dn_kind) == KIND_CYC && $past(dn_axis[1:0]) == 2'h3;
   endproperty
   a_strb_order: assert property (p_strb_order) else $error("strobe not after last axis");
   property p_axis_seq;
      dn_valid && dn_kind == KIND_CYC && dn_axis[1:0] != 2'h3 |=> dn_valid && dn_kind == KIND_CYC
         && dn_axis[1:0] == $past(dn_axis[1:0]) + 2'h1;
   endproperty
   a_axis_seq: assert property (p_axis_seq) else $error("cyclic axis sequence broken");
   property p_ccyc;
      strb && seen_reg |-> cnt_reg == 16'(CC - 1);
   endproperty
   a_ccyc: assert property (p_ccyc) else $error("controller cycle length wrong");
   property p_svc_once;
      svc && seen_reg |-> svcn_reg == 2'h0;
   endproperty
   a_svc_once: assert property (p_svc_once) else $error("second service frame in cycle");
   property p_svc_sep;
      strb |=> !svc [*8];
   endproperty
   a_svc_sep: assert property (p_svc_sep) else $error("service next to cyclic frames");
   property p_cyc_resp;
      strb |-> ##[2:7] up_valid && up_kind == KIND_CYC;
   endproperty
   a_cyc_resp: assert property (p_cyc_resp) else $error("no cyclic response after strobe");
   property p_addr_once;
      adr |-> !adrn_reg;
   endproperty
   a_addr_once: assert property (p_addr_once) else $error("address frame repeated");
   property p_up_kind;
      up_valid |-> up_kind == KIND_CYC || up_kind == KIND_SVC;
   endproperty
   a_up_kind: assert property (p_up_kind) else $error("bad response kind");
   c_strb: cover property (strb);
   c_svc: cover property (svc);
   c_svc_resp: cover property (up_valid && up_kind == KIND_SVC);
endmodule
`default_nettype wire

/* sim/drive_cycle_buffer_scheduler_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_cycle_buffer_scheduler_tb;
   import dcbs_pkg::*;
   // ****************************************
   // Bench for controller and node pair
   // ****************************************
   localparam logic [ADDR_W-1:0] ADR = 8'h05;
   localparam int CC = DCYC_PER_CCYC * DRIVE_CYC_CLKS;
   logic sys_clk_i, rst_i, svc_req_i, svc_busy_o, ccyc_start_o, resp_valid_o;
   logic drive_update_o, drive_cycle_o, addr_valid_o, svc_seen_o;
   logic [ADDR_W-1:0] node_addr_i, node_addr_o;
   logic [AXIS_W-1:0] svc_axis_i, resp_axis_o;
   logic [NODE_AXES*DATA_W-1:0] demand_i, drive_resp_i, param_i, drive_demand_o;
   logic [1:0] resp_kind_o;
   logic [DATA_W-1:0] resp_data_o;
   int fails = 0;
   int n_tests = 0;
   dcbs_link_if link();
   dcbs_ctrl i_dcbs_ctrl(.sys_clk_i, .rst_i, .link(link), .node_addr_i, .demand_i,
      .svc_req_i, .svc_axis_i, .svc_busy_o, .ccyc_start_o, .resp_valid_o, .resp_kind_o,
      .resp_axis_o, .resp_data_o);
   dcbs_node i_dcbs_node(.sys_clk_i, .rst_i, .link(link), .drive_demand_o, .drive_update_o,
      .drive_cycle_o, .node_addr_o, .addr_valid_o, .svc_seen_o, .drive_resp_i, .param_i);
   dcbs_link_sva i_dcbs_link_sva(.sys_clk_i, .rst_i, .dn_valid(link.dn_valid),
      .dn_kind(link.dn_kind), .dn_node(link.dn_node), .dn_axis(link.dn_axis),
      .dn_data(link.dn_data), .up_valid(link.up_valid), .up_kind(link.up_kind),
      .up_node(link.up_node), .up_axis(link.up_axis), .up_data(link.up_data));
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   function automatic logic pl(input int s);
      return s == 0 ? drive_cycle_o : s == 1 ? ccyc_start_o : drive_update_o;
   endfunction
   // Bounded wait for the next pulse of one output
   task automatic wt(input int s, output int n);
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (pl(s) !== 1'b1 && n < 2 * CC);
   endtask
   // Write a demand, then read back the cyclic responses
   task automatic wr_dem(input logic [127:0] d);
      int n, a;
      demand_i = d;
      wt(2, n);
      wt(2, n);
      chk(drive_update_o, 1'b1);
      chk(drive_demand_o, d);
      a = 0;
      for (int k = 0; k < 12; k++) begin
         @(negedge sys_clk_i);
         if (k == 0) chk(drive_update_o, 1'b0);
         if (resp_valid_o === 1'b1 && resp_kind_o === KIND_CYC) begin
            chk(resp_axis_o[1:0], a[1:0]);
            chk(resp_data_o, drive_resp_i[a*DATA_W +: DATA_W]);
            a++;
         end
      end
      chk(a, NODE_AXES);
   endtask
   // Service query of one axis
   task automatic svc(input logic [AXIS_W-1:0] ax);
      int n;
      logic seen;
      seen = 1'b0;
      svc_req_i = 1'b1;
      svc_axis_i = ax;
      @(negedge sys_clk_i);
      svc_req_i = 1'b0;
      chk(svc_busy_o, 1'b1);
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
         if (svc_seen_o === 1'b1) seen = 1'b1;
      end while (n < 2 * CC && !(resp_valid_o === 1'b1 && resp_kind_o === KIND_SVC));
      chk(n <= CC + DRIVE_CYC_CLKS + 16, 1'b1);
      chk(seen, 1'b1);
      chk(svc_busy_o, 1'b0);
      chk(resp_axis_o, ax);
      chk(resp_data_o, param_i[ax[1:0]*DATA_W +: DATA_W]);
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (90000) @(posedge sys_clk_i);
      fails++;
      test_done();
   end
   initial begin
      int n;
      rst_i = 1'b1;
      svc_req_i = 1'b0;
      svc_axis_i = 5'h0;
      node_addr_i = ADR;
      demand_i = 128'h0;
      drive_resp_i = 128'hd4000004_c3000003_b2000002_a1000001;
      param_i = 128'h7f00ff04_6e00ee03_5d00dd02_4c00cc01;
      repeat (16) @(negedge sys_clk_i);
      rst_i = 1'b0;
      wt(2, n);
      chk(node_addr_o, ADR);
      chk(addr_valid_o, 1'b1);
      wr_dem(128'h44440004_33330003_22220002_11110001);
      wr_dem(128'h0bbb000b_0aaa000a_09990009_08880008);
      wt(0, n);
      wt(0, n);
      chk(n, DRIVE_CYC_CLKS);
      wt(1, n);
      wt(1, n);
      chk(n, CC);
      svc(5'h0);
      svc(5'h3);
      // Frames for another node ignored, strobe still common
      node_addr_i = ADR + 8'h1;
      demand_i = 128'h0;
      wt(1, n);
      wt(2, n);
      chk(n, 7);
      chk(drive_demand_o, 128'h0bbb000b_0aaa000a_09990009_08880008);
      node_addr_i = ADR;
      wt(2, n);
      chk(drive_demand_o, 128'h0);
      test_done();
   end
endmodule
`default_nettype wire
